// ==== logic/dswd_defines.svh ====
`ifndef DSWD_DEFINES_SVH
`define DSWD_DEFINES_SVH

// Source count and per-source register layout
`define DSWD_NSRC 7
`define DSWD_EN_BIT 0
`define DSWD_SEL_LSB 1
`define DSWD_SEL_MSB 3
`define DSWD_CFG_RESET 4'h0

// Detection selector codes
`define DSWD_SEL_LOW 3'h0
`define DSWD_SEL_HIGH 3'h1
`define DSWD_SEL_LPULSE 3'h2
`define DSWD_SEL_HPULSE 3'h3
`define DSWD_SEL_BOTH 3'h4

// Register indices; byte address is four times the index
`define DSWD_CFG_BASE_IDX 6'h20
`define DSWD_STAT_IDX 6'h28
`define DSWD_MASK_IDX 6'h29

// Bus decode
`define DSWD_ADDR_W 12
`define DSWD_IDX_MSB 7
`define DSWD_IDX_LSB 2

`endif

// ==== logic/dswd_detect.sv ====
`timescale 1ns/100ps
`include "dswd_defines.svh"

module dswd_detect (
  input wire logic clk,
  input wire logic reset_n,
  input dswd_pkg::dswd_cfg_t cfg,
  input wire logic wakeRaw,
  output logic evt
);

  logic sync1_r;
  logic sync2_r;
  logic prev_r;
  logic evt_r;
  logic evt_nxt;
  logic rise;
  logic fall;

  assign rise = sync2_r && !prev_r;
  assign fall = !sync2_r && prev_r;
  assign evt = evt_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Event decode from the synchronised level
  always_comb begin
    evt_nxt = 1'b0;
    if (cfg.detectOn) begin
      case (cfg.detectSel)
        `DSWD_SEL_LOW: evt_nxt = !sync2_r;
        `DSWD_SEL_HIGH: evt_nxt = sync2_r;
        `DSWD_SEL_LPULSE: evt_nxt = fall;
        `DSWD_SEL_HPULSE: evt_nxt = rise;
        `DSWD_SEL_BOTH: evt_nxt = rise || fall;
        default: evt_nxt = 1'b0;
      endcase
    end
  end

  // Two-stage synchroniser, history and event register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r <= 1'b0;
      evt_r <= 1'b0;
    end else begin
      sync1_r <= wakeRaw;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
      evt_r <= evt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_LOW_LEVEL: assert property (@(posedge clk) disable iff (!reset_n)
    (cfg.detectOn && cfg.detectSel == `DSWD_SEL_LOW && !sync2_r) |=> evt_r)
    else $error("low level not detected");
  AST_HIGH_LEVEL: assert property (@(posedge clk) disable iff (!reset_n)
    (cfg.detectOn && cfg.detectSel == `DSWD_SEL_HIGH) |=> (evt_r == $past(sync2_r)))
    else $error("high level detection wrong");
  AST_LOW_PULSE: assert property (@(posedge clk) disable iff (!reset_n)
    (cfg.detectOn && cfg.detectSel == `DSWD_SEL_LPULSE) |=> (evt_r == $past(fall)))
    else $error("low pulse detection wrong");
  AST_HIGH_PULSE: assert property (@(posedge clk) disable iff (!reset_n)
    (cfg.detectOn && cfg.detectSel == `DSWD_SEL_HPULSE && rise) |=> evt_r)
    else $error("high pulse not detected");
  AST_BOTH_EDGES: assert property (@(posedge clk) disable iff (!reset_n)
    (cfg.detectOn && cfg.detectSel == `DSWD_SEL_BOTH) |=> (evt_r == $past(rise || fall)))
    else $error("edge detection wrong");
  AST_DISABLED: assert property (@(posedge clk) disable iff (!reset_n)
    !cfg.detectOn |=> !evt_r)
    else $error("event while disabled");
  AST_RESERVED: assert property (@(posedge clk) disable iff (!reset_n)
    (cfg.detectSel[2] && (cfg.detectSel[1] || cfg.detectSel[0])) |=> !evt_r)
    else $error("event on reserved code");

endmodule

// ==== logic/dswd_pkg.sv ====
package dswd_pkg;

  // One source's configuration
  typedef struct packed {
    logic [2:0] detectSel;
    logic detectOn;
  } dswd_cfg_t;

  // Bus answer sequencer
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACK = 2'b10
  } dswd_state_t;

endpackage

// ==== logic/dswd_top.sv ====
// Our own choices: the address map and register access over APB.
`timescale 1ns/100ps
`include "dswd_defines.svh"

module dswd_top #(
  parameter int NSRC = `DSWD_NSRC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`DSWD_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [NSRC-1:0] wakeIn,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq
);

  dswd_pkg::dswd_cfg_t cfg_r [NSRC];
  dswd_pkg::dswd_cfg_t cfg_nxt [NSRC];
  dswd_pkg::dswd_state_t state_r;
  dswd_pkg::dswd_state_t state_nxt;
  logic [NSRC-1:0] status_r;
  logic [NSRC-1:0] status_nxt;
  logic [NSRC-1:0] mask_r;
  logic [NSRC-1:0] mask_nxt;
  logic [NSRC-1:0] evt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  logic irq_r;
  logic irq_nxt;
  logic [5:0] idx;
  logic inWindow;
  logic hit;
  logic [31:0] rdVal;
  logic [NSRC-1:0] clrBits;

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;

  ////////////////////////////////////////////////////////////////////////////////
  // One detector per source, each fed only by its own pin and register
  for (genvar i = 0; i < NSRC; i++) begin : g_src
    dswd_detect u_det (
      .clk(clk),
      .reset_n(reset_n),
      .cfg(cfg_r[i]),
      .wakeRaw(wakeIn[i]),
      .evt(evt[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode and read mux
  assign idx = paddr[`DSWD_IDX_MSB:`DSWD_IDX_LSB];
  assign inWindow = (paddr[`DSWD_ADDR_W-1:`DSWD_IDX_MSB+1] == '0)
    && (paddr[`DSWD_IDX_LSB-1:0] == '0);

  always_comb begin
    hit = 1'b0;
    rdVal = 32'h0;
    if (inWindow) begin
      for (int i = 0; i < NSRC; i++) begin
        if (idx == `DSWD_CFG_BASE_IDX + 6'(i)) begin
          hit = 1'b1;
          rdVal[`DSWD_SEL_MSB:`DSWD_EN_BIT] = cfg_r[i];
        end
      end
      if (idx == `DSWD_STAT_IDX) begin
        hit = 1'b1;
        rdVal[NSRC-1:0] = status_r;
      end
      if (idx == `DSWD_MASK_IDX) begin
        hit = 1'b1;
        rdVal[NSRC-1:0] = mask_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus sequencer, register writes, sticky status and interrupt
  always_comb begin
    state_nxt = state_r;
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    prdata_nxt = prdata_r;
    cfg_nxt = cfg_r;
    mask_nxt = mask_r;
    clrBits = '0;
    case (state_r)
      dswd_pkg::ST_IDLE: begin
        if (psel && penable) begin
          pready_nxt = 1'b1;
          pslverr_nxt = !hit;
          prdata_nxt = pwrite ? 32'h0 : rdVal;
          state_nxt = dswd_pkg::ST_ACK;
        end
      end
      dswd_pkg::ST_ACK: begin
        state_nxt = dswd_pkg::ST_IDLE;
        if (psel && penable && pwrite && hit) begin
          for (int i = 0; i < NSRC; i++) begin
            if (idx == `DSWD_CFG_BASE_IDX + 6'(i)) begin
              cfg_nxt[i] = pwdata[`DSWD_SEL_MSB:`DSWD_EN_BIT];
            end
          end
          if (idx == `DSWD_STAT_IDX) begin
            clrBits = pwdata[NSRC-1:0];
          end
          if (idx == `DSWD_MASK_IDX) begin
            mask_nxt = pwdata[NSRC-1:0];
          end
        end
      end
      default: state_nxt = dswd_pkg::ST_IDLE;
    endcase
    // A new event beats a clear in the same cycle
    status_nxt = (status_r & ~clrBits) | evt;
    irq_nxt = |(status_nxt & mask_nxt);
  end

  // State registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= dswd_pkg::ST_IDLE;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
      status_r <= '0;
      mask_r <= '0;
      irq_r <= 1'b0;
      for (int i = 0; i < NSRC; i++) begin
        cfg_r[i] <= `DSWD_CFG_RESET;
      end
    end else begin
      state_r <= state_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      irq_r <= irq_nxt;
      cfg_r <= cfg_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_access;
    psel && penable && !pready_r;
  endsequence

  sequence s_cfg0_write;
    psel && penable && pready_r && pwrite && inWindow && idx == `DSWD_CFG_BASE_IDX;
  endsequence

  AST_ONE_WAIT: assert property (@(posedge clk) disable iff (!reset_n)
    s_access |=> pready_r ##1 !pready_r)
    else $error("answer not after one wait cycle");
  AST_CFG0_STORE: assert property (@(posedge clk) disable iff (!reset_n)
    s_cfg0_write |=> (cfg_r[0] == $past(pwdata[`DSWD_SEL_MSB:`DSWD_EN_BIT])))
    else $error("source 0 register not written");
  AST_CFG_ISOLATE: assert property (@(posedge clk) disable iff (!reset_n)
    s_cfg0_write |=> (cfg_r[1] == $past(cfg_r[1])))
    else $error("write leaked to another source");
  AST_SET_WINS: assert property (@(posedge clk) disable iff (!reset_n)
    evt[0] |=> status_r[0])
    else $error("event lost");
  AST_IRQ_RAISE: assert property (@(posedge clk) disable iff (!reset_n)
    (|(evt & mask_nxt)) |=> irq)
    else $error("unmasked event gave no interrupt");
  AST_UNMAPPED: assert property (@(posedge clk) disable iff (!reset_n)
    (psel && penable && !pready_r && !hit) |=> (pready_r && pslverr_r))
    else $error("unmapped access not flagged");

  ////////////////////////////////////////////////////////////////////////////////
  // Accepted writes and first access cycles
  logic ackWrite;
  logic statWr;
  logic maskWr;
  assign ackWrite = psel && penable && pready_r && pwrite && hit;
  assign statWr = ackWrite && (idx == `DSWD_STAT_IDX);
  assign maskWr = ackWrite && (idx == `DSWD_MASK_IDX);

  sequence s_read_access;
    psel && penable && !pready_r && !pwrite;
  endsequence

  sequence s_write_access;
    psel && penable && !pready_r && pwrite;
  endsequence

  // Ready is a single-cycle pulse
  AST_READY_PULSE: assert property (@(posedge clk) disable iff (!reset_n)
    pready_r |=> !pready_r)
    else $error("ready held longer than one cycle");

  // Error flag only comes with ready
  AST_ERR_WITH_READY: assert property (@(posedge clk) disable iff (!reset_n)
    pslverr_r |-> pready_r)
    else $error("error flag without ready");

  // No answer without an access
  AST_IDLE_QUIET: assert property (@(posedge clk) disable iff (!reset_n)
    !(psel && penable) |=> !pready_r)
    else $error("ready without access");

  // Write answers carry no data
  AST_WRITE_NO_DATA: assert property (@(posedge clk) disable iff (!reset_n)
    s_write_access |=> (prdata_r == 32'h0))
    else $error("write answer carries data");

  // Status read returns the sticky bits
  AST_READ_STATUS: assert property (@(posedge clk) disable iff (!reset_n)
    (psel && penable && !pready_r && !pwrite && inWindow && idx == `DSWD_STAT_IDX)
    |=> (prdata_r == 32'($past(status_r))))
    else $error("status read wrong");

  // Mask read returns the mask
  AST_READ_MASK: assert property (@(posedge clk) disable iff (!reset_n)
    (psel && penable && !pready_r && !pwrite && inWindow && idx == `DSWD_MASK_IDX)
    |=> (prdata_r == 32'($past(mask_r))))
    else $error("mask read wrong");

  // Unmapped reads return zero
  AST_READ_UNMAPPED: assert property (@(posedge clk) disable iff (!reset_n)
    (psel && penable && !pready_r && !pwrite && !hit) |=> (prdata_r == 32'h0))
    else $error("unmapped read not zero");

  // Unused upper bits always read zero
  AST_UPPER_ZERO: assert property (@(posedge clk) disable iff (!reset_n)
    s_read_access |=> (prdata_r[31:NSRC] == '0))
    else $error("upper read bits not zero");

  // Mask write lands
  AST_MASK_STORE: assert property (@(posedge clk) disable iff (!reset_n)
    maskWr |=> (mask_r == $past(pwdata[NSRC-1:0])))
    else $error("mask not written");

  // Writes to unmapped addresses leave the mask unchanged
  AST_BAD_WRITE_IGNORED: assert property (@(posedge clk) disable iff (!reset_n)
    (psel && penable && pready_r && pwrite && !hit) |=> (mask_r == $past(mask_r)))
    else $error("unmapped write changed the mask");

  // Interrupt is high exactly while an unmasked status bit is set
  AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (!reset_n)
    irq_r == |(status_r & mask_r))
    else $error("interrupt level wrong");

  // Per-source status, configuration and detection checks
  for (genvar k = 0; k < NSRC; k++) begin : g_chk
    // Event sets its own status bit
    AST_SRC_SET: assert property (@(posedge clk) disable iff (!reset_n)
      evt[k] |=> status_r[k])
      else $error("source event did not set its status bit");

    // Writing one clears the bit when no event competes
    AST_SRC_CLEAR: assert property (@(posedge clk) disable iff (!reset_n)
      (statWr && pwdata[k] && !evt[k]) |=> !status_r[k])
      else $error("status bit not cleared");

    // Status is sticky until cleared
    AST_SRC_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
      (status_r[k] && !(statWr && pwdata[k])) |=> status_r[k])
      else $error("status bit dropped");

    // Only a write to its own index changes a source register
    AST_SRC_CFG_KEEP: assert property (@(posedge clk) disable iff (!reset_n)
      !(ackWrite && idx == `DSWD_CFG_BASE_IDX + 6'(k)) |=> (cfg_r[k] == $past(cfg_r[k])))
      else $error("source register changed without a write");

    // Source register reads back
    AST_SRC_CFG_READ: assert property (@(posedge clk) disable iff (!reset_n)
      (s_read_access ##0 (inWindow && idx == `DSWD_CFG_BASE_IDX + 6'(k)))
      |=> (prdata_r[`DSWD_SEL_MSB:`DSWD_EN_BIT] == $past(cfg_r[k])))
      else $error("source register read wrong");

    // Disabled source gives no event
    AST_SRC_EN_GATE: assert property (@(posedge clk) disable iff (!reset_n)
      !cfg_r[k].detectOn |=> !evt[k])
      else $error("event from disabled source");

    // Reserved selector gives no event
    AST_SRC_RESERVED: assert property (@(posedge clk) disable iff (!reset_n)
      (cfg_r[k].detectSel[2] && (cfg_r[k].detectSel[1] || cfg_r[k].detectSel[0]))
      |=> !evt[k])
      else $error("event from reserved selector");
  end

endmodule

// ==== sim/deep_stop_wake_detect_tb_top.sv ====
`timescale 1ns/100ps
`include "dswd_defines.svh"

module deep_stop_wake_detect_tb_top;
  localparam logic [11:0] STAT = 12'(`DSWD_STAT_IDX * 4);
  localparam logic [11:0] MASK = 12'(`DSWD_MASK_IDX * 4);
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [6:0] lvlReq = 7'h00;
  logic [6:0] wakeIn;
  logic [31:0] prdata, q;
  logic pready, pslverr, irq, e, idle, exp;
  logic [2:0] sel;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int src;

  ////////////////////////////////////////////////////////////////
  // Clock, design and wake sources
  always #5 clk = ~clk;
  dswd_top #(.NSRC(7)) uut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .wakeIn(wakeIn), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq));
  dswd_wake_model srcs (.clk(clk), .lvlReq(lvlReq), .wakeIn(wakeIn));

  ////////////////////////////////////////////////////////////////
  // Bus tasks and comparison
  function automatic logic [11:0] cfgA(int i);
    return 12'((`DSWD_CFG_BASE_IDX + i) * 4);
  endfunction

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] got);
    n_tests++;
    if (got !== x) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, x, got);
      err_count++;
    end
  endtask

  // One transfer: setup, access held until pready, then release
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rq, output logic re);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) err_count++;
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x, input string nm);
    apb(1'b0, a, 32'h0, q, e);
    chk(nm, x, q);
  endtask

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(cfgA(0), 32'h0, "cfg reset");
    rd(STAT, 32'h0, "status reset");
    rd(MASK, 32'h0, "mask reset");
    $display("test reset done");
    // Every source keeps its own word, reserved codes included, upper bits read 0
    for (int i = 0; i < 7; i++) apb(1'b1, cfgA(i), 32'hfffffff0 | 32'(i << 1), q, e);
    for (int i = 0; i < 7; i++) rd(cfgA(i), 32'(i << 1), "cfg readback");
    apb(1'b0, 12'h09c, 32'h0, q, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
    $display("test registers done");
    for (int i = 0; i < 7; i++) apb(1'b1, cfgA(i), 32'h0, q, e);
    apb(1'b1, MASK, 32'h3f, q, e);
    // Every selector code, then a disabled source; source 6 is masked out
    for (int c = 0; c < 9; c++) begin
      src = (c + 6) % 7;
      sel = (c == 8) ? 3'h3 : 3'(c);
      idle = (c == 0 || c == 2 || c == 4);
      exp = (c < 5);
      lvlReq <= 7'(idle) << src;
      apb(1'b1, cfgA(src), {28'h0, sel, c != 8}, q, e);
      repeat (8) @(posedge clk);
      apb(1'b1, STAT, 32'h7f, q, e);
      rd(STAT, 32'h0, "status cleared");
      lvlReq <= 7'(!idle) << src;
      repeat (8) @(posedge clk);
      rd(STAT, 32'(exp) << src, "status");
      chk("irq", {31'h0, exp && src != 6}, {31'h0, irq});
      apb(1'b1, cfgA(src), 32'h0, q, e);
      $display("test mode %0d done", c);
    end
    print_verdict();
  end
endmodule

// ==== sim/dswd_wake_model.sv ====
`timescale 1ns/100ps

// Wake sources seen from the block: pins change only just after a clock edge
module dswd_wake_model (
  input wire logic clk,
  input wire logic [6:0] lvlReq,
  output logic [6:0] wakeIn
);
  // Drive the commanded pin levels, low until the first edge
  initial wakeIn = 7'h00;
  always @(posedge clk) begin
    wakeIn <= lvlReq;
  end
endmodule
